// [design/graphics_interrupt_unit.sv]
// interrupt collector of the graphics accelerator with apb registers
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module graphics_interrupt_unit (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fifoAccess,
    input wire logic readyHold,
    output logic hostReady,
    output logic accumClear,
    input wire logic dmaTc,
    input wire logic pixelWritten,
    input wire logic vsyncIn,
    input wire logic [1:0] extIrqN,
    output logic isaIrq,
    output logic intaOut,
    output logic intaOe
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    gfx_irq_pkg::src_s status_q, status_d;
    logic [5:0] ien_q, ien_d;
    logic [1:0] cfg_q, cfg_d;
    logic [7:0] aux_q, aux_d;
    logic [7:0] vre_q, vre_d;
    logic [1:0] extEn_q, extEn_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic vsPrev_q;
    logic [1:0] extS1_q, extS2_q, extS3_q;
    logic [1:0] extLvl_q, extLvl_d;
    logic [5:0] activePrev_q;
    logic isaIrq_q, isaIrq_d;
    logic intaOe_q, intaOe_d;

    logic bfErrSet;
    logic iclrWr;
    logic setup, wrAcc;
    logic [5:0] active;
    logic [5:0] setVec, clrVec;
    logic vsRise, vsClear, levelMode, pciMode;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == gfx_irq_pkg::OFF_STATUS) || (a == gfx_irq_pkg::OFF_IEN) ||
                 (a == gfx_irq_pkg::OFF_ICLR) || (a == gfx_irq_pkg::OFF_CONFIG) ||
                 (a == gfx_irq_pkg::OFF_AUX) || (a == gfx_irq_pkg::OFF_VRE) ||
                 (a == gfx_irq_pkg::OFF_EXT);
    endfunction

    function automatic logic wrTo(input logic acc, input logic [7:0] a,
                                  input logic [7:0] off);
        wrTo = acc && (a == off);
    endfunction

    // ----------------------------------------------------------------
    // bus fifo watchdog
    // ----------------------------------------------------------------
    bus_fifo_watchdog watchdog (
        .clock(clock),
        .rst(rst),
        .fifoAccess(fifoAccess),
        .readyHold(readyHold),
        .hostReady(hostReady),
        .bfErrSet(bfErrSet),
        .accumClear(accumClear)
    );

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    // zero wait states: read data is captured in the setup cycle
    assign setup = psel && !penable;
    assign wrAcc = psel && penable && pwrite;
    assign pready = psel && penable;
    assign pslverr = pready && err_q;
    assign prdata = rdata_q;

    always_comb begin
        rdata_d = rdata_q;
        err_d = err_q;
        if (setup) begin
            err_d = !mapped(paddr);
            unique case (paddr)
                gfx_irq_pkg::OFF_STATUS: rdata_d = {26'h0, status_q};
                gfx_irq_pkg::OFF_IEN: rdata_d = {26'h0, ien_q};
                gfx_irq_pkg::OFF_CONFIG: rdata_d = {30'h0, cfg_q};
                gfx_irq_pkg::OFF_AUX: rdata_d = {24'h0, aux_q};
                gfx_irq_pkg::OFF_VRE: rdata_d = {24'h0, vre_q};
                gfx_irq_pkg::OFF_EXT: rdata_d = {28'h0, extLvl_q, extEn_q};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_comb begin
        ien_d = ien_q;
        cfg_d = cfg_q;
        aux_d = aux_q;
        vre_d = vre_q;
        extEn_d = extEn_q;
        if (wrTo(wrAcc, paddr, gfx_irq_pkg::OFF_IEN)) begin
            ien_d = pwdata[5:0];
        end
        if (wrTo(wrAcc, paddr, gfx_irq_pkg::OFF_CONFIG)) begin
            cfg_d = pwdata[1:0];
        end
        if (wrTo(wrAcc, paddr, gfx_irq_pkg::OFF_AUX)) begin
            aux_d = pwdata[7:0];
        end
        if (wrTo(wrAcc, paddr, gfx_irq_pkg::OFF_VRE)) begin
            vre_d = pwdata[7:0];
        end
        if (wrTo(wrAcc, paddr, gfx_irq_pkg::OFF_EXT)) begin
            extEn_d = pwdata[1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ien_q <= gfx_irq_pkg::IEN_RST;
            cfg_q <= gfx_irq_pkg::CFG_RST;
            aux_q <= gfx_irq_pkg::AUX_RST;
            vre_q <= gfx_irq_pkg::VRE_RST;
            extEn_q <= gfx_irq_pkg::EXT_EN_RST;
            rdata_q <= 32'h0;
            err_q <= 1'b0;
        end else begin
            ien_q <= ien_d;
            cfg_q <= cfg_d;
            aux_q <= aux_d;
            vre_q <= vre_d;
            extEn_q <= extEn_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // ----------------------------------------------------------------
    // external interrupt pins
    // ----------------------------------------------------------------
    // a level change is taken only when the last two stages agree
    always_comb begin
        extLvl_d = extLvl_q;
        for (int i = 0; i < 2; i++) begin
            if (extS2_q[i] == extS3_q[i]) begin
                extLvl_d[i] = !extS3_q[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            extS1_q <= 2'h3;
            extS2_q <= 2'h3;
            extS3_q <= 2'h3;
            extLvl_q <= 2'h0;
            vsPrev_q <= 1'b0;
        end else begin
            extS1_q <= extIrqN;
            extS2_q <= extS1_q;
            extS3_q <= extS2_q;
            extLvl_q <= extLvl_d;
            vsPrev_q <= vsyncIn;
        end
    end

    // ----------------------------------------------------------------
    // sticky status
    // ----------------------------------------------------------------
    assign vsRise = vsyncIn && !vsPrev_q;
    assign iclrWr = wrTo(wrAcc, paddr, gfx_irq_pkg::OFF_ICLR);
    // writing the retrace end register with bit 4 low acknowledges vsync
    assign vsClear = wrTo(wrAcc, paddr, gfx_irq_pkg::OFF_VRE) &&
                     !pwdata[gfx_irq_pkg::VRE_VSYNC_CLR_BIT];

    always_comb begin
        setVec = '0;
        setVec[gfx_irq_pkg::SRC_BFERR] = bfErrSet;
        setVec[gfx_irq_pkg::SRC_DMATC] = dmaTc;
        setVec[gfx_irq_pkg::SRC_PICK] = pixelWritten;
        setVec[gfx_irq_pkg::SRC_VSYNC] = vsRise;
        setVec[gfx_irq_pkg::SRC_EXT0] = extLvl_q[0];
        setVec[gfx_irq_pkg::SRC_EXT1] = extLvl_q[1];
        clrVec = '0;
        if (iclrWr) begin
            clrVec = pwdata[5:0];
        end
        clrVec[gfx_irq_pkg::SRC_VSYNC] = vsClear;
        // a source event in the clearing cycle survives the clear
        status_d = (status_q & ~clrVec) | setVec;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            status_q <= gfx_irq_pkg::STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    // ----------------------------------------------------------------
    // interrupt output
    // ----------------------------------------------------------------
    assign levelMode = cfg_q[gfx_irq_pkg::CFG_LEVEL_BIT];
    assign pciMode = cfg_q[gfx_irq_pkg::CFG_PCI_BIT];

    always_comb begin
        active = status_q & ien_q;
        active[gfx_irq_pkg::SRC_VSYNC] = status_q.vsync &&
            ien_q[gfx_irq_pkg::SRC_VSYNC] && aux_q[gfx_irq_pkg::AUX_VSYNC_BIT] &&
            vre_q[gfx_irq_pkg::VRE_VSYNC_EN_BIT];
        // external sources only reach the host through the pci line
        active[gfx_irq_pkg::SRC_EXT0] = status_q.ext0 && ien_q[gfx_irq_pkg::SRC_EXT0] &&
            extEn_q[0] && pciMode;
        active[gfx_irq_pkg::SRC_EXT1] = status_q.ext1 && ien_q[gfx_irq_pkg::SRC_EXT1] &&
            extEn_q[1] && pciMode;
        isaIrq_d = 1'b0;
        intaOe_d = 1'b0;
        if (pciMode) begin
            intaOe_d = |active;
        end else if (levelMode) begin
            isaIrq_d = |active;
        end else begin
            // edge mode: one pulse when a source newly becomes active
            isaIrq_d = |(active & ~activePrev_q);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            activePrev_q <= 6'h00;
            isaIrq_q <= 1'b0;
            intaOe_q <= 1'b0;
        end else begin
            activePrev_q <= active;
            isaIrq_q <= isaIrq_d;
            intaOe_q <= intaOe_d;
        end
    end

    assign isaIrq = isaIrq_q;
    assign intaOe = intaOe_q;
    // open-drain line: only ever pulled low
    assign intaOut = 1'b0;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    AST_BFERR_SETS: assert property (bfErrSet |=> status_q.bfErr)
        else $error("bus error event not recorded");
    AST_DMATC_SETS: assert property (dmaTc |=> status_q.dmaTc)
        else $error("terminal count not recorded");
    AST_PICK_SETS: assert property (pixelWritten |=> status_q.pick)
        else $error("picking event not recorded");
    AST_VSYNC_SETS: assert property (vsyncIn && !vsPrev_q |=> status_q.vsync)
        else $error("vsync edge not recorded");
    AST_VSYNC_GATE: assert property (
        !(aux_q[gfx_irq_pkg::AUX_VSYNC_BIT] && vre_q[gfx_irq_pkg::VRE_VSYNC_EN_BIT])
        |-> !active[gfx_irq_pkg::SRC_VSYNC])
        else $error("vsync active without both gate bits");
    AST_VSYNC_CLR: assert property (vsClear && !vsRise |=> !status_q.vsync)
        else $error("retrace end write did not clear vsync");
    AST_VSYNC_KEEP: assert property (status_q.vsync && !vsClear |=> status_q.vsync)
        else $error("vsync cleared without a retrace end write");
    AST_ICLR_KEEPS_VS: assert property (
        status_q.vsync && !vsClear && iclrWr
        |=> status_q.vsync)
        else $error("clear register removed vsync");
    AST_ICLR_BFERR: assert property (
        iclrWr && pwdata[gfx_irq_pkg::SRC_BFERR] && !bfErrSet |=> !status_q.bfErr)
        else $error("clear register did not clear bus error");
    AST_ICLR_DMATC: assert property (
        iclrWr && pwdata[gfx_irq_pkg::SRC_DMATC] && !dmaTc |=> !status_q.dmaTc)
        else $error("clear register did not clear terminal count");
    AST_ICLR_PICK: assert property (
        iclrWr && pwdata[gfx_irq_pkg::SRC_PICK] && !pixelWritten |=> !status_q.pick)
        else $error("clear register did not clear picking");
    AST_ICLR_EXT0: assert property (
        iclrWr && pwdata[gfx_irq_pkg::SRC_EXT0] && !extLvl_q[0] |=> !status_q.ext0)
        else $error("clear register did not clear external 0");
    AST_DMATC_HOLDS: assert property (
        status_q.dmaTc && !(iclrWr && pwdata[gfx_irq_pkg::SRC_DMATC]) |=> status_q.dmaTc)
        else $error("terminal count status lost without a clear");
    AST_EXT0_SETS: assert property (extLvl_q[0] |=> status_q.ext0)
        else $error("external pin 0 not recorded");
    AST_EXT1_SETS: assert property (extLvl_q[1] |=> status_q.ext1)
        else $error("external pin 1 not recorded");

    // ----------------------------------------------------------------
    // output checks
    // ----------------------------------------------------------------
    AST_LEVEL_OUT: assert property (
        !pciMode && levelMode && (|active) && $stable(cfg_q) |=> isaIrq)
        else $error("level interrupt not raised");
    AST_LEVEL_DROP: assert property (!pciMode && levelMode && !(|active) |=> !isaIrq)
        else $error("level interrupt held without an active source");
    AST_EDGE_PULSE: assert property (
        !pciMode && !levelMode && (|(active & ~activePrev_q)) |=> isaIrq)
        else $error("edge interrupt pulse missing");
    AST_EDGE_QUIET: assert property (
        !pciMode && !levelMode && !(|(active & ~activePrev_q)) |=> !isaIrq)
        else $error("edge interrupt pulse without a new source");
    AST_PCI_LINE: assert property (pciMode && (|active) |=> intaOe ##0 !isaIrq)
        else $error("pci line not driven or isa line active");
    AST_PCI_IDLE: assert property (pciMode && !(|active) |=> !intaOe)
        else $error("pci line driven without an active source");
    AST_ISA_NO_INTA: assert property (!pciMode |=> !intaOe)
        else $error("pci line driven in isa configuration");

    // ----------------------------------------------------------------
    // register checks
    // ----------------------------------------------------------------
    AST_STATUS_READ: assert property (
        setup && paddr == gfx_irq_pkg::OFF_STATUS |=> prdata[5:0] == $past(status_q))
        else $error("status read mismatch");
    AST_EXT_READ: assert property (
        setup && paddr == gfx_irq_pkg::OFF_EXT |=>
        prdata[3:0] == {$past(extLvl_q), $past(extEn_q)})
        else $error("external level read mismatch");
    AST_IEN_WRITE: assert property (
        wrTo(wrAcc, paddr, gfx_irq_pkg::OFF_IEN) |=> ien_q == $past(pwdata[5:0]))
        else $error("enable register write lost");
    AST_CFG_WRITE: assert property (
        wrTo(wrAcc, paddr, gfx_irq_pkg::OFF_CONFIG) |=> cfg_q == $past(pwdata[1:0]))
        else $error("configuration write lost");
    AST_EXT_EN_WRITE: assert property (
        wrTo(wrAcc, paddr, gfx_irq_pkg::OFF_EXT) |=> extEn_q == $past(pwdata[1:0]))
        else $error("external enable write lost");
endmodule

// [design/gfx_irq_pkg.sv]
// constants, types and register map of the graphics interrupt unit
package gfx_irq_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_IEN = 8'h04;
    localparam logic [7:0] OFF_ICLR = 8'h08;
    localparam logic [7:0] OFF_CONFIG = 8'h0c;
    localparam logic [7:0] OFF_AUX = 8'h10;
    localparam logic [7:0] OFF_VRE = 8'h14;
    localparam logic [7:0] OFF_EXT = 8'h18;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int NSRC = 6;
    localparam int SRC_BFERR = 0;
    localparam int SRC_DMATC = 1;
    localparam int SRC_PICK = 2;
    localparam int SRC_VSYNC = 3;
    localparam int SRC_EXT0 = 4;
    localparam int SRC_EXT1 = 5;
    localparam int CFG_LEVEL_BIT = 0;
    localparam int CFG_PCI_BIT = 1;
    localparam int AUX_VSYNC_BIT = 7;
    localparam int VRE_VSYNC_EN_BIT = 5;
    localparam int VRE_VSYNC_CLR_BIT = 4;

    // ----------------------------------------------------------------
    // reset values and counts
    // ----------------------------------------------------------------
    localparam logic [5:0] IEN_RST = 6'h00;
    localparam logic [5:0] STATUS_RST = 6'h00;
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam logic [7:0] AUX_RST = 8'h00;
    localparam logic [7:0] VRE_RST = 8'h00;
    localparam logic [1:0] EXT_EN_RST = 2'h0;
    localparam int CNT_W = 8;
    localparam logic [7:0] BFERR_CLKS = 8'h40;
    localparam logic [7:0] ABORT_CLKS = 8'h80;

    typedef struct packed {
        logic ext1;
        logic ext0;
        logic vsync;
        logic pick;
        logic dmaTc;
        logic bfErr;
    } src_s;

    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_COUNT = 2'b01,
        WD_LATE = 2'b11,
        WD_ABORT = 2'b10
    } wd_state_e;

endpackage

// [design/bus_fifo_watchdog.sv]
// bus fifo access watchdog: flags late ready and aborts stuck cycles
`timescale 1ns/1ps
module bus_fifo_watchdog (
    input wire logic clock,
    input wire logic rst,
    input wire logic fifoAccess,
    input wire logic readyHold,
    output logic hostReady,
    output logic bfErrSet,
    output logic accumClear
);
    gfx_irq_pkg::wd_state_e state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic err_q, err_d;
    logic stall;

    assign stall = fifoAccess && readyHold;
    // the abort cycle releases ready even though the host section still holds it
    assign hostReady = !readyHold || (state_q == gfx_irq_pkg::WD_ABORT);
    assign accumClear = (state_q == gfx_irq_pkg::WD_ABORT);
    assign bfErrSet = err_q;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        err_d = 1'b0;
        unique case (state_q)
            gfx_irq_pkg::WD_IDLE: begin
                cnt_d = 8'h01;
                if (stall) begin
                    state_d = gfx_irq_pkg::WD_COUNT;
                end
            end
            gfx_irq_pkg::WD_COUNT: begin
                cnt_d = cnt_q + 8'h01;
                if (!stall) begin
                    state_d = gfx_irq_pkg::WD_IDLE;
                end else if (cnt_q == gfx_irq_pkg::BFERR_CLKS) begin
                    state_d = gfx_irq_pkg::WD_LATE;
                    err_d = 1'b1;
                end
            end
            gfx_irq_pkg::WD_LATE: begin
                cnt_d = cnt_q + 8'h01;
                if (!stall) begin
                    state_d = gfx_irq_pkg::WD_IDLE;
                end else if (cnt_q == gfx_irq_pkg::ABORT_CLKS) begin
                    state_d = gfx_irq_pkg::WD_ABORT;
                end
            end
            gfx_irq_pkg::WD_ABORT: begin
                state_d = gfx_irq_pkg::WD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= gfx_irq_pkg::WD_IDLE;
            cnt_q <= 8'h00;
            err_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            err_q <= err_d;
        end
    end

    AST_WD_ERR_TIME: assert property (@(posedge clock) disable iff (rst)
        bfErrSet |-> $past(cnt_q) == gfx_irq_pkg::BFERR_CLKS && $past(stall))
        else $error("late-ready error not at 65th stalled cycle");
    AST_WD_ABORT_REL: assert property (@(posedge clock) disable iff (rst)
        accumClear |-> hostReady ##1 !accumClear)
        else $error("abort did not release ready for one cycle");
endmodule

// [tb/host_irq_model.sv]
// host side model: resolves the open-drain inta wire and counts isa edges
`timescale 1ns/1ps
module host_irq_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic isaIrq,
    input wire logic intaOut,
    input wire logic intaOe,
    output logic intaLineN,
    output logic [7:0] isaEdges
);
    logic isaPrev_q;

    // ----------------------------------------
    // shared interrupt wire
    // ----------------------------------------
    // released wire floats up through the board pull-up
    assign intaLineN = intaOe ? intaOut : 1'b1;

    always_ff @(posedge clock) begin
        if (rst) begin
            isaPrev_q <= 1'b0;
            isaEdges <= 8'h00;
        end else begin
            isaPrev_q <= isaIrq;
            // edge-triggered host input latches only rising transitions
            if (isaIrq && !isaPrev_q) begin
                isaEdges <= isaEdges + 8'h01;
            end
        end
    end
endmodule

// [tb/graphics_interrupt_unit_tb_top.sv]
// self-checking bench of the graphics interrupt unit
`timescale 1ns/1ps
module graphics_interrupt_unit_tb_top;
    logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, hostReady, accumClear, isaIrq, intaOut, intaOe, intaLineN;
    logic fifoAccess = 1'b0, readyHold = 1'b0, dmaTc = 1'b0, pixelWritten = 1'b0;
    logic vsyncIn = 1'b0, lastErr;
    logic [1:0] extIrqN = 2'b11;
    logic [7:0] isaEdges, e0;
    int failCount = 0, totalChecks = 0, cycles = 0, t0, n;

    graphics_interrupt_unit i_graphics_interrupt_unit (.clock(clock), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fifoAccess(fifoAccess),
        .readyHold(readyHold), .hostReady(hostReady), .accumClear(accumClear),
        .dmaTc(dmaTc), .pixelWritten(pixelWritten), .vsyncIn(vsyncIn), .extIrqN(extIrqN),
        .isaIrq(isaIrq), .intaOut(intaOut), .intaOe(intaOe));
    host_irq_model i_host_irq_model (.clock(clock), .rst(rst), .isaIrq(isaIrq),
        .intaOut(intaOut), .intaOe(intaOe), .intaLineN(intaLineN), .isaEdges(isaEdges));

    initial begin
        forever #25 clock = ~clock;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic report_and_stop;
        if (failCount == 0 && totalChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            failCount++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        totalChecks++;
        if (g !== e) begin
            failCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
    endtask

    // one apb transfer; waits for pready, then releases and lets an edge pass
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // only the bench timeout ends a slave that never answers
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rdata = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        for (int i = 0; i < 6; i++) rdchk(8'(i * 4), 32'h0);
        rdchk(8'h1c, 32'h0);
        chk(32'(lastErr), 32'h1);
        wr(gfx_irq_pkg::OFF_IEN, 32'h3f);
        rdchk(gfx_irq_pkg::OFF_IEN, 32'h3f);
        wr(gfx_irq_pkg::OFF_IEN, 32'h0);
    endtask

    task automatic t_events;
        dmaTc <= 1'b1;
        pixelWritten <= 1'b1;
        vsyncIn <= 1'b1;
        cyc(1);
        dmaTc <= 1'b0;
        pixelWritten <= 1'b0;
        cyc(2);
        rdchk(gfx_irq_pkg::OFF_STATUS, 32'h0e);
        wr(gfx_irq_pkg::OFF_ICLR, 32'h3f);
        rdchk(gfx_irq_pkg::OFF_STATUS, 32'h08);
        wr(gfx_irq_pkg::OFF_CONFIG, 32'h1);
        wr(gfx_irq_pkg::OFF_IEN, 32'h08);
        chk(32'(isaIrq), 32'h0);
        wr(gfx_irq_pkg::OFF_AUX, 32'h80);
        chk(32'(isaIrq), 32'h0);
        wr(gfx_irq_pkg::OFF_VRE, 32'h30);
        cyc(1);
        chk(32'(isaIrq), 32'h1);
        // sync still high: clearing must not re-arm until the next rising edge
        wr(gfx_irq_pkg::OFF_VRE, 32'h20);
        rdchk(gfx_irq_pkg::OFF_STATUS, 32'h0);
        chk(32'(isaIrq), 32'h0);
        vsyncIn <= 1'b0;
    endtask

    task automatic t_isa_modes;
        wr(gfx_irq_pkg::OFF_IEN, 32'h02);
        dmaTc <= 1'b1;
        cyc(1);
        dmaTc <= 1'b0;
        cyc(4);
        chk(32'(isaIrq), 32'h1);
        wr(gfx_irq_pkg::OFF_ICLR, 32'h02);
        cyc(1);
        chk(32'(isaIrq), 32'h0);
        wr(gfx_irq_pkg::OFF_CONFIG, 32'h0);
        e0 = isaEdges;
        dmaTc <= 1'b1;
        cyc(1);
        dmaTc <= 1'b0;
        cyc(5);
        chk(32'(isaEdges - e0), 32'h1);
        chk(32'(isaIrq), 32'h0);
        wr(gfx_irq_pkg::OFF_ICLR, 32'h02);
    endtask

    task automatic t_watchdog;
        wr(gfx_irq_pkg::OFF_CONFIG, 32'h1);
        wr(gfx_irq_pkg::OFF_IEN, 32'h01);
        fifoAccess <= 1'b1;
        readyHold <= 1'b1;
        cyc(50);
        readyHold <= 1'b0;
        cyc(1);
        readyHold <= 1'b1;
        t0 = cycles;
        cyc(50);
        rdchk(gfx_irq_pkg::OFF_STATUS, 32'h0);
        chk(32'(hostReady), 32'h0);
        cyc(15);
        rdchk(gfx_irq_pkg::OFF_STATUS, 32'h01);
        chk(32'(isaIrq), 32'h1);
        n = 0;
        while (hostReady !== 1'b1 && n < 80) begin
            @(posedge clock);
            n++;
        end
        chk(32'(accumClear), 32'h1);
        chk(32'(cycles - t0 >= 128 && cycles - t0 <= 131), 32'h1);
        cyc(1);
        chk(32'(hostReady), 32'h0);
        fifoAccess <= 1'b0;
        readyHold <= 1'b0;
        wr(gfx_irq_pkg::OFF_ICLR, 32'h01);
        cyc(1);
        chk(32'(isaIrq), 32'h0);
    endtask

    task automatic t_pci;
        wr(gfx_irq_pkg::OFF_CONFIG, 32'h3);
        wr(gfx_irq_pkg::OFF_EXT, 32'h3);
        wr(gfx_irq_pkg::OFF_IEN, 32'h30);
        extIrqN <= 2'b10;
        cyc(8);
        rdchk(gfx_irq_pkg::OFF_EXT, 32'h07);
        extIrqN <= 2'b11;
        cyc(6);
        rdchk(gfx_irq_pkg::OFF_STATUS, 32'h10);
        rdchk(gfx_irq_pkg::OFF_EXT, 32'h03);
        chk(32'(intaLineN), 32'h0);
        chk(32'(isaIrq), 32'h0);
        wr(gfx_irq_pkg::OFF_ICLR, 32'h10);
        cyc(1);
        chk(32'(intaLineN), 32'h1);
        extIrqN <= 2'b01;
        cyc(8);
        extIrqN <= 2'b11;
        cyc(6);
        rdchk(gfx_irq_pkg::OFF_STATUS, 32'h20);
        chk(32'(intaLineN), 32'h0);
        wr(gfx_irq_pkg::OFF_ICLR, 32'h20);
        cyc(1);
        chk(32'(intaLineN), 32'h1);
        wr(gfx_irq_pkg::OFF_IEN, 32'h04);
        pixelWritten <= 1'b1;
        cyc(1);
        pixelWritten <= 1'b0;
        cyc(4);
        chk(32'(intaLineN), 32'h0);
    endtask

    initial begin
        cyc(10);
        rst <= 1'b0;
        cyc(1);
        t_regs();
        t_events();
        t_isa_modes();
        t_watchdog();
        t_pci();
        report_and_stop();
    end
endmodule
